// ===== design/dgn_pkg.sv
// Notes on behaviour
// - indicator rises when input exceeds upper threshold
// - dwell count runs while input below lower
// - input above lower during dwell resets count
// - indicator drops when dwell count reaches zero
// - quiet scale when inactive, loud when active
// - scale applied ahead of resampling filter input
// - two ports, independent set points, selectable
// - programmable delay aligns scale with converter latency
// - 32-bit complex oscillator with I/Q mixing
// - frequency word unsigned over two registers
// - writes to shadow, active loads from shadow
// - frequency readback returns the active register
// - wake or hop loads hold-off, fires at one
// - hold-off one is immediate, zero blocks
// - 16-bit phase offset added to accumulator
// - bypass routes port A to I, B to Q
// - control bit 1 dithers phase truncation
// - control bit 2 dithers amplitude quantization
// - bit 3 clears accumulator on frequency change while awake
// - control bit 6 selects port B input
// - bits 8:7 pick sync pin, pin enabled
// - scale applies even when resampler is bypassed
package dgn_pkg;

  // register offsets
  localparam logic [7:0] ADDR_HOLDOFF = 8'h84;
  localparam logic [7:0] ADDR_FREQ_LO = 8'h85;
  localparam logic [7:0] ADDR_FREQ_HI = 8'h86;
  localparam logic [7:0] ADDR_PHASE = 8'h87;
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_SCALE = 8'h92;
  localparam int REG_W = 20;

  // oscillator control fields
  localparam int CTRL_BYPASS = 0;
  localparam int CTRL_PH_DITHER = 1;
  localparam int CTRL_AMP_DITHER = 2;
  localparam int CTRL_CLR_HOP = 3;
  localparam int CTRL_INPUT_B = 6;
  localparam int CTRL_SYNC_LO = 7;
  localparam int CTRL_W = 9;

  // scale register fields
  localparam int SCALE_LOUD_LO = 0;
  localparam int SCALE_QUIET_LO = 5;
  localparam int SCALE_W = 5;

  // values after reset
  localparam logic [15:0] RST_HOLDOFF = 16'h0000;
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [8:0] RST_CTRL = 9'h000;
  localparam logic [9:0] RST_SCALE = 10'h000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // datapath figures
  localparam int ADC_LATENCY = 7;
  localparam int LUT_W = 11;
  localparam int BYP_SHIFT = 8;

  // level indicator states
  typedef enum logic [1:0] {LI_QUIET, LI_LOUD, LI_DWELL} dgn_li_state_t;

endpackage

// ===== design/dgn_channel_front.sv
`timescale 1ns/1ps
module dgn_channel_front
  import dgn_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int DWELL_W = 16,
  parameter int DELAY_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // converter sample streams
  input wire logic signed [DATA_W-1:0] adc_a_data,
  input wire logic signed [DATA_W-1:0] adc_b_data,
  // gain switching set points
  input wire logic [DATA_W-1:0] upper_thresh_a,
  input wire logic [DATA_W-1:0] lower_thresh_a,
  input wire logic [DATA_W-1:0] upper_thresh_b,
  input wire logic [DATA_W-1:0] lower_thresh_b,
  input wire logic [DWELL_W-1:0] dwell_count_a,
  input wire logic [DWELL_W-1:0] dwell_count_b,
  input wire logic [$clog2(DELAY_DEPTH)-1:0] gain_delay,
  // sleep and sync pins
  input wire logic channel_sleep,
  input wire logic sync_pin_a,
  input wire logic sync_pin_b,
  input wire logic sync_pin_c,
  input wire logic sync_pin_d,
  input wire logic [3:0] pin_sync_enable,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_W-1:0] reg_rdata,
  // level indicators
  output logic level_indicator_port_a,
  output logic level_indicator_port_b,
  output logic level_indicator_out,
  // samples toward the resampling filter
  output logic signed [DATA_W+LUT_W-1:0] filt_in_i,
  output logic signed [DATA_W+LUT_W-1:0] filt_in_q
);

  localparam int PROD_W = DATA_W + LUT_W;
  localparam int DLY_W = $clog2(DELAY_DEPTH);

  // refuse shapes the datapath cannot serve
  if (DATA_W < 4 || DATA_W > 16 || DWELL_W < 1 || DELAY_DEPTH <= ADC_LATENCY) begin : g_bad_param
    $error("dgn_channel_front: unsupported parameter values");
  end

  // magnitude of a signed sample
  function automatic logic [DATA_W-1:0] mag_of(input logic signed [DATA_W-1:0] s);
    logic [DATA_W-1:0] m;
    m = s[DATA_W-1] ? DATA_W'(-s) : DATA_W'(s);
    return m;
  endfunction

  // quarter wave lookup with optional amplitude dither
  function automatic logic signed [LUT_W-1:0] wave(input logic [5:0] idx, input logic ad);
    logic [3:0] a;
    logic [9:0] m;
    logic [9:0] r;
    a = idx[4] ? ~idx[3:0] : idx[3:0];
    case (a)
      4'h0: m = 10'h019;
      4'h1: m = 10'h04B;
      4'h2: m = 10'h07C;
      4'h3: m = 10'h0AC;
      4'h4: m = 10'h0DA;
      4'h5: m = 10'h107;
      4'h6: m = 10'h130;
      4'h7: m = 10'h157;
      4'h8: m = 10'h17B;
      4'h9: m = 10'h19A;
      4'hA: m = 10'h1B6;
      4'hB: m = 10'h1CE;
      4'hC: m = 10'h1E1;
      4'hD: m = 10'h1F0;
      4'hE: m = 10'h1F9;
      default: m = 10'h1FE;
    endcase
    r = (m + {9'h000, ad}) >> 1;
    return idx[5] ? -LUT_W'(r) : LUT_W'(r);
  endfunction

  // per-port views
  logic signed [DATA_W-1:0] smp [2];
  logic [DATA_W-1:0] upr [2];
  logic [DATA_W-1:0] lwr [2];
  logic [DWELL_W-1:0] dwl [2];
  logic li [2];

  assign smp[0] = adc_a_data;
  assign smp[1] = adc_b_data;
  assign upr[0] = upper_thresh_a;
  assign upr[1] = upper_thresh_b;
  assign lwr[0] = lower_thresh_a;
  assign lwr[1] = lower_thresh_b;
  assign dwl[0] = dwell_count_a;
  assign dwl[1] = dwell_count_b;

  // one threshold and dwell circuit per input port
  genvar p;
  for (p = 0; p < 2; p++) begin : g_port
    dgn_li_state_t st_reg;
    logic [DWELL_W-1:0] cnt_reg;
    logic [DATA_W-1:0] mag;

    assign mag = mag_of(smp[p]);

    // hysteresis state machine, evaluated every cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        st_reg <= LI_QUIET;
        cnt_reg <= '0;
      end else begin
        case (st_reg)
          LI_QUIET: begin
            if (mag > upr[p]) begin
              st_reg <= LI_LOUD;
            end
          end
          LI_LOUD: begin
            if (mag < lwr[p]) begin
              st_reg <= LI_DWELL;
              cnt_reg <= dwl[p];
            end
          end
          LI_DWELL: begin
            if (mag >= lwr[p]) begin
              st_reg <= LI_LOUD;
            end else if (cnt_reg == '0) begin
              st_reg <= LI_QUIET;
            end else begin
              cnt_reg <= cnt_reg - 1'b1;
            end
          end
          default: st_reg <= LI_QUIET;
        endcase
      end
    end

    assign li[p] = (st_reg != LI_QUIET);
  end

  assign level_indicator_port_a = li[0];
  assign level_indicator_port_b = li[1];

  // software registers
  logic [15:0] holdoff_reg;
  logic [31:0] shadow_freq_reg;
  logic [31:0] active_freq_reg;
  logic [15:0] phase_off_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [9:0] scale_reg;

  // register writes; frequency lands in the shadow only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdoff_reg <= RST_HOLDOFF;
      shadow_freq_reg <= RST_FREQ;
      phase_off_reg <= RST_PHASE;
      ctrl_reg <= RST_CTRL;
      scale_reg <= RST_SCALE;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_HOLDOFF: holdoff_reg <= reg_wdata[15:0];
        ADDR_FREQ_LO: shadow_freq_reg[15:0] <= reg_wdata[15:0];
        ADDR_FREQ_HI: shadow_freq_reg[31:16] <= reg_wdata[15:0];
        ADDR_PHASE: phase_off_reg <= reg_wdata[15:0];
        ADDR_CTRL: ctrl_reg <= reg_wdata[CTRL_W-1:0];
        ADDR_SCALE: scale_reg <= reg_wdata[9:0];
        default: ;
      endcase
    end
  end

  // read mux, frequency shows the active word
  logic [REG_W-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (reg_addr)
      ADDR_HOLDOFF: rd_val = {4'h0, holdoff_reg};
      ADDR_FREQ_LO: rd_val = {4'h0, active_freq_reg[15:0]};
      ADDR_FREQ_HI: rd_val = {4'h0, active_freq_reg[31:16]};
      ADDR_PHASE: rd_val = {4'h0, phase_off_reg};
      ADDR_CTRL: rd_val = {11'h000, ctrl_reg};
      ADDR_SCALE: rd_val = {10'h000, scale_reg};
      default: rd_val = '0;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

  // wake and sync hop detection
  logic sleep_d_reg;
  logic sync_d_reg;
  logic [3:0] sync_vec;
  logic [1:0] sync_sel;
  logic sync_now;
  logic wake;
  logic hop;
  logic evt;

  assign sync_vec = {sync_pin_d, sync_pin_c, sync_pin_b, sync_pin_a};
  assign sync_sel = ctrl_reg[CTRL_SYNC_LO +: 2];
  assign sync_now = sync_vec[sync_sel] & pin_sync_enable[sync_sel];
  assign wake = sleep_d_reg & ~channel_sleep;
  assign hop = sync_now & ~sync_d_reg;
  assign evt = wake | hop;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_d_reg <= 1'b1;
      sync_d_reg <= 1'b0;
    end else begin
      sleep_d_reg <= channel_sleep;
      sync_d_reg <= sync_now;
    end
  end

  // hold-off countdown toward a frequency update
  logic [15:0] hold_cnt_reg;
  logic fire;

  assign fire = (evt && holdoff_reg == 16'h0001) || (hold_cnt_reg == 16'h0001);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_reg <= 16'h0000;
    end else if (evt && holdoff_reg > 16'h0001) begin
      hold_cnt_reg <= holdoff_reg - 16'h0001;
    end else if (hold_cnt_reg != 16'h0000) begin
      hold_cnt_reg <= hold_cnt_reg - 16'h0001;
    end
  end

  // active word loads only from the shadow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_freq_reg <= RST_FREQ;
    end else if (fire) begin
      active_freq_reg <= shadow_freq_reg;
    end
  end

  // phase accumulator, frozen while asleep
  logic [31:0] acc_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 32'h0000_0000;
    end else if (channel_sleep) begin
      acc_reg <= acc_reg;
    end else if (fire && ctrl_reg[CTRL_CLR_HOP]) begin
      acc_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_reg + active_freq_reg;
    end
  end

  // dither source
  logic [15:0] lfsr_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_reg <= LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // phase with offset and optional truncation dither
  logic [15:0] ph_dith;
  logic [15:0] phase;
  logic amp_dith;
  logic signed [LUT_W-1:0] sin_v;
  logic signed [LUT_W-1:0] cos_v;

  assign ph_dith = ctrl_reg[CTRL_PH_DITHER] ? {6'h00, lfsr_reg[9:0]} : 16'h0000;
  assign phase = acc_reg[31:16] + phase_off_reg + ph_dith;
  assign amp_dith = ctrl_reg[CTRL_AMP_DITHER] & lfsr_reg[15];
  assign sin_v = wave(phase[15:10], amp_dith);
  assign cos_v = wave(phase[15:10] + 6'h10, amp_dith);

  // input select and mixing
  logic sel_b;
  logic signed [DATA_W-1:0] x;
  assign sel_b = ctrl_reg[CTRL_INPUT_B];
  assign x = sel_b ? adc_b_data : adc_a_data;

  logic signed [PROD_W-1:0] mix_i_reg;
  logic signed [PROD_W-1:0] mix_q_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mix_i_reg <= '0;
      mix_q_reg <= '0;
    end else if (ctrl_reg[CTRL_BYPASS]) begin
      mix_i_reg <= PROD_W'(adc_a_data) <<< BYP_SHIFT;
      mix_q_reg <= PROD_W'(adc_b_data) <<< BYP_SHIFT;
    end else begin
      mix_i_reg <= PROD_W'(x) * PROD_W'(cos_v);
      mix_q_reg <= -(PROD_W'(x) * PROD_W'(sin_v));
    end
  end

  // indicator delay line for alignment with the converter
  logic [DELAY_DEPTH-1:0] li_pipe_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      li_pipe_reg <= '0;
    end else begin
      li_pipe_reg <= {li_pipe_reg[DELAY_DEPTH-2:0], li[sel_b]};
    end
  end

  assign level_indicator_out = li_pipe_reg[gain_delay];

  // gain selection and scaling ahead of the filter
  logic [SCALE_W-1:0] scale_sel;
  assign scale_sel = level_indicator_out ? scale_reg[SCALE_LOUD_LO +: SCALE_W]
                                         : scale_reg[SCALE_QUIET_LO +: SCALE_W];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_in_i <= '0;
      filt_in_q <= '0;
    end else begin
      filt_in_i <= mix_i_reg >>> scale_sel;
      filt_in_q <= mix_q_reg >>> scale_sel;
    end
  end

  // checks
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_go_dwell;
    g_port[0].st_reg == LI_LOUD && g_port[0].mag < lower_thresh_a;
  endsequence

  sequence s_hold5;
    evt && holdoff_reg == 16'h0005 ##1 hold_cnt_reg == 16'h0004 ##3 hold_cnt_reg == 16'h0001;
  endsequence

  chk_li_rise_upper: assert property (
    g_port[0].st_reg == LI_QUIET && g_port[0].mag > upper_thresh_a |=> level_indicator_port_a)
    else $error("indicator missed upper crossing");

  chk_dwell_load: assert property (
    s_go_dwell |=> g_port[0].st_reg == LI_DWELL && g_port[0].cnt_reg == $past(dwell_count_a))
    else $error("dwell count not loaded");

  chk_dwell_restart: assert property (
    g_port[0].st_reg == LI_DWELL && g_port[0].mag >= lower_thresh_a
    |=> g_port[0].st_reg == LI_LOUD && level_indicator_port_a)
    else $error("dwell not reset on rise");

  chk_dwell_end: assert property (
    g_port[0].st_reg == LI_DWELL && g_port[0].cnt_reg == '0 && g_port[0].mag < lower_thresh_a
    |=> !level_indicator_port_a)
    else $error("indicator held past terminal count");

  chk_quiet_scale: assert property (
    !level_indicator_out |=> filt_in_i == ($past(mix_i_reg) >>> $past(scale_reg[9:5])))
    else $error("quiet scale not applied");

  chk_holdoff_fire: assert property (
    s_hold5 |=> active_freq_reg == $past(shadow_freq_reg))
    else $error("hold-off did not update frequency");

  chk_holdoff_one: assert property (
    evt && holdoff_reg == 16'h0001 |=> active_freq_reg == $past(shadow_freq_reg))
    else $error("hold-off one not immediate");

  chk_holdoff_zero: assert property (
    holdoff_reg == 16'h0000 && hold_cnt_reg == 16'h0000 |=> $stable(active_freq_reg))
    else $error("frequency changed with hold-off zero");

  chk_read_active: assert property (
    reg_rd && reg_addr == ADDR_FREQ_HI |=> reg_rdata == {4'h0, $past(active_freq_reg[31:16])})
    else $error("readback not from active word");

  chk_clear_hop: assert property (
    fire && ctrl_reg[CTRL_CLR_HOP] && !channel_sleep |=> acc_reg == 32'h0000_0000)
    else $error("accumulator not cleared on hop");

  chk_bypass_path: assert property (
    ctrl_reg[CTRL_BYPASS] |=> mix_q_reg == (PROD_W'($past(adc_b_data)) <<< BYP_SHIFT))
    else $error("bypass did not route port B to Q");

endmodule

// ===== test/dgn_adc_model.sv
`timescale 1ns/1ps
// partner: two converter streams whose level the bench commands
module dgn_adc_model (
  // clock
  input wire logic sys_clk,
  // commanded levels and sign toggling
  input wire logic signed [11:0] amp_a,
  input wire logic signed [11:0] amp_b,
  input wire logic alt,
  // sample streams
  output wire logic signed [11:0] adc_a_data,
  output wire logic signed [11:0] adc_b_data
);
  logic flip = 1'b0;
  // sign flips every cycle while alt is set, so magnitude, not value, must be compared
  always @(negedge sys_clk) begin
    flip <= ~flip;
  end
  // one new sample per clock, held across the sampling edge
  assign adc_a_data = (alt && flip) ? -amp_a : amp_a;
  assign adc_b_data = (alt && flip) ? -amp_b : amp_b;
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dgn_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [11:0] amp_a = 12'h000;
  logic signed [11:0] amp_b = 12'h000;
  logic alt = 1'b0;
  wire logic signed [11:0] adc_a_data;
  wire logic signed [11:0] adc_b_data;
  logic [11:0] thr_ua = 12'h3E8;
  logic [11:0] thr_la = 12'h1F4;
  logic [11:0] thr_ub = 12'h5DC;
  logic [11:0] thr_lb = 12'h0C8;
  logic [15:0] dwell_a = 16'h0002;
  logic [15:0] dwell_b = 16'h0002;
  logic [3:0] gain_delay = 4'h3;
  logic channel_sleep = 1'b1;
  logic [3:0] sync_pins = 4'h0;
  logic [3:0] pin_sync_enable = 4'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [REG_W-1:0] reg_wdata = 20'h00000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_W-1:0] reg_rdata;
  logic li_a, li_b, li_out;
  logic signed [22:0] filt_in_i, filt_in_q;
  logic [7:0] rst_addr [7] = '{ADDR_HOLDOFF, ADDR_FREQ_LO, ADDR_FREQ_HI, ADDR_PHASE, ADDR_CTRL, ADDR_SCALE, 8'h90};
  logic [REG_W-1:0] ctrl_tab [3] = '{20'h00002, 20'h00004, 20'h00006};
  logic [REG_W-1:0] cur;
  int err_total = 0;
  int n_tests = 0;

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  dgn_adc_model adc (.sys_clk(sys_clk), .amp_a(amp_a), .amp_b(amp_b), .alt(alt),
    .adc_a_data(adc_a_data), .adc_b_data(adc_b_data));

  dgn_channel_front DUT (.sys_clk(sys_clk), .rst_n(rst_n), .adc_a_data(adc_a_data), .adc_b_data(adc_b_data),
    .upper_thresh_a(thr_ua), .lower_thresh_a(thr_la), .upper_thresh_b(thr_ub), .lower_thresh_b(thr_lb),
    .dwell_count_a(dwell_a), .dwell_count_b(dwell_b), .gain_delay(gain_delay), .channel_sleep(channel_sleep),
    .sync_pin_a(sync_pins[0]), .sync_pin_b(sync_pins[1]), .sync_pin_c(sync_pins[2]), .sync_pin_d(sync_pins[3]),
    .pin_sync_enable(pin_sync_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .level_indicator_port_a(li_a), .level_indicator_port_b(li_b),
    .level_indicator_out(li_out), .filt_in_i(filt_in_i), .filt_in_q(filt_in_q));

  // mismatch report
  task automatic fail(input string m);
    err_total++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("register read %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) fail($sformatf("indicator %b expected %b", got, exp));
  endtask
  task automatic chk_smp(input logic signed [22:0] got, input logic signed [22:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("sample %h expected %h", got, exp));
  endtask
  // expected scaled bypass sample
  function automatic logic signed [22:0] exp_smp(input logic signed [11:0] v, input int s);
    logic signed [22:0] t;
    t = 23'(v);
    return (t <<< 8) >>> s;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [REG_W-1:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // register read, data settled after the taking edge
  task automatic rd_chk(input logic [7:0] a, input logic [REG_W-1:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk_reg(reg_rdata, e);
  endtask
  // two-cycle pulse on one sync pin
  task automatic hop(input int k);
    @(negedge sys_clk);
    sync_pins[k] = 1'b1;
    cyc(2);
    sync_pins[k] = 1'b0;
  endtask
  // counts, verdict, end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    fork
      begin
        #40000;
        err_total++;
        complete_run();
      end
    join_none
    cyc(10);
    rst_n = 1'b1;
    // reset values and unmapped place
    for (int i = 0; i < 7; i++) rd_chk(rst_addr[i], 20'h00000);
    wr(ADDR_SCALE, 20'h000A3);
    rd_chk(ADDR_SCALE, 20'h000A3);
    wr(ADDR_PHASE, 20'h0FFFF);
    rd_chk(ADDR_PHASE, 20'h0FFFF);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, ctrl_tab[i]);
      rd_chk(ADDR_CTRL, ctrl_tab[i]);
    end
    wr(8'h90, 20'h12345);
    rd_chk(8'h90, 20'h00000);
    // shadow write, wake loads active
    wr(ADDR_FREQ_LO, 20'h01234);
    wr(ADDR_FREQ_HI, 20'h0ABCD);
    rd_chk(ADDR_FREQ_LO, 20'h00000);
    wr(ADDR_HOLDOFF, 20'h00001);
    channel_sleep = 1'b0;
    cyc(3);
    rd_chk(ADDR_FREQ_LO, 20'h01234);
    rd_chk(ADDR_FREQ_HI, 20'h0ABCD);
    // hold-off zero blocks a hop
    wr(ADDR_HOLDOFF, 20'h00000);
    wr(ADDR_FREQ_LO, 20'h05555);
    pin_sync_enable = 4'h1;
    hop(0);
    cyc(8);
    rd_chk(ADDR_FREQ_LO, 20'h01234);
    // each sync pin, unselected pin ignored
    wr(ADDR_HOLDOFF, 20'h00001);
    cur = 20'h01234;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, {11'h000, 2'(k), 7'h08});
      pin_sync_enable = 4'h1 << k;
      wr(ADDR_FREQ_LO, 20'(k + 1));
      hop((k + 1) % 4);
      cyc(2);
      rd_chk(ADDR_FREQ_LO, cur);
      hop(k);
      cyc(2);
      cur = 20'(k + 1);
      rd_chk(ADDR_FREQ_LO, cur);
    end
    // longer hold-off delays the update
    wr(ADDR_HOLDOFF, 20'h00005);
    wr(ADDR_FREQ_LO, 20'h00077);
    hop(3);
    rd_chk(ADDR_FREQ_LO, cur);
    cyc(6);
    rd_chk(ADDR_FREQ_LO, 20'h00077);
    // indicator on port A, port B set points differ
    wr(ADDR_CTRL, 20'h00000);
    alt = 1'b1;
    amp_a = 12'h4B0;
    amp_b = 12'h4B0;
    cyc(1);
    chk_bit(li_a, 1'b1);
    chk_bit(li_b, 1'b0);
    cyc(3);
    chk_bit(li_out, 1'b0);
    cyc(1);
    chk_bit(li_out, 1'b1);
    amp_b = 12'h064;
    amp_a = 12'h064;
    cyc(2);
    amp_a = 12'h258;
    cyc(1);
    amp_a = 12'h064;
    cyc(3);
    chk_bit(li_a, 1'b1);
    cyc(1);
    chk_bit(li_a, 1'b0);
    // port B selected as monitored input
    wr(ADDR_CTRL, 20'h00040);
    amp_b = 12'h640;
    cyc(1);
    chk_bit(li_b, 1'b1);
    cyc(6);
    chk_bit(li_out, 1'b1);
    amp_b = 12'h064;
    cyc(8);
    chk_bit(li_out, 1'b0);
    // bypass path, quiet then loud scale
    alt = 1'b0;
    wr(ADDR_CTRL, 20'h00001);
    wr(ADDR_SCALE, 20'h00043);
    amp_a = 12'h12C;
    amp_b = 12'hF9C;
    cyc(10);
    chk_smp(filt_in_i, exp_smp(amp_a, 2));
    chk_smp(filt_in_q, exp_smp(amp_b, 2));
    amp_a = 12'h4B0;
    gain_delay = 4'h0;
    cyc(2);
    chk_bit(li_out, 1'b1);
    cyc(10);
    chk_smp(filt_in_i, exp_smp(amp_a, 3));
    chk_smp(filt_in_q, exp_smp(amp_b, 3));
    complete_run();
  end
endmodule
